// ### imtc_pkg.sv
// package of register map, field positions, status codes and carriers
package imtc_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DIVIDER = 8'h0c;
  // control register bit positions
  localparam int B_WAIT = 7;
  localparam int B_ACKEN = 6;
  localparam int B_START = 5;
  localparam int B_STOP = 4;
  localparam int B_WCOL = 3;
  localparam int B_EN = 2;
  localparam int B_RSVD = 1;
  localparam int B_IRQEN = 0;
  // status codes, prescaler bits at zero
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_D_ACK = 8'h28;
  localparam logic [7:0] ST_D_NACK = 8'h30;
  localparam logic [7:0] ST_AR_ACK = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_IDLE = 8'hf8;
  localparam logic [7:0] STATUS_MASK = 8'hf8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hff;
  localparam logic [7:0] DIV_RESET = 8'h7c;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // byte engine commands
  typedef enum logic [1:0] {CMD_START, CMD_BYTE, CMD_STOP} imtc_cmd_t;
  typedef struct packed {
    logic valid;
    imtc_cmd_t cmd;
    logic [7:0] data;
  } imtc_req_t;
  typedef struct packed {
    logic done;
    logic ack;
  } imtc_rsp_t;
endpackage : imtc_pkg

// ### imtc_bit_engine.sv
// bit-level line engine: start, byte plus ack, stop on scl/sda
`timescale 1ns/1ps
module imtc_bit_engine (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // quarter-bit enable and request/answer
  input wire logic tick,
  input wire imtc_pkg::imtc_req_t req,
  output imtc_pkg::imtc_rsp_t rsp,
  // synchronised line levels
  input wire logic scl_in,
  input wire logic sda_in,
  // open-drain drives, enable high pulls low
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] rx_byte
);
  typedef enum logic [2:0] {E_IDLE, E_START, E_BIT, E_ACK, E_STOP}
    imtc_eng_t;
  imtc_eng_t state;
  logic [1:0] phase;
  logic [3:0] nbit;
  logic [7:0] sh;
  logic last_phase;
  assign last_phase = tick && phase == 2'h3;
  // four ticks per bit; scl held low after a start or a byte, released after a stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= E_IDLE;
      phase <= 2'h0;
      nbit <= 4'h0;
      sh <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rsp <= '0;
      rx_byte <= 8'h00;
    end else begin
      rsp.done <= 1'b0;
      if (tick && state != E_IDLE) phase <= phase + 2'h1;
      case (state)
        E_IDLE: begin
          phase <= 2'h0;
          if (req.valid) begin
            case (req.cmd)
              imtc_pkg::CMD_START: state <= E_START;
              imtc_pkg::CMD_BYTE: begin
                state <= E_BIT;
                sh <= req.data;
                nbit <= 4'h0;
              end
              default: state <= E_STOP;
            endcase
          end
        end
        E_START: begin
          // sda released, scl released, sda falls, scl falls
          if (tick) begin
            case (phase)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b1;
              default: scl_oe <= 1'b1;
            endcase
          end
          if (last_phase) begin
            state <= E_IDLE;
            rsp <= '{done: 1'b1, ack: 1'b0};
          end
        end
        E_BIT: begin
          if (tick) begin
            case (phase)
              2'h0: sda_oe <= ~sh[7];
              2'h1: scl_oe <= 1'b0;
              2'h2: rx_byte <= {rx_byte[6:0], sda_in};
              default: scl_oe <= 1'b1;
            endcase
          end
          if (last_phase) begin
            sh <= {sh[6:0], 1'b0};
            nbit <= nbit + 4'h1;
            if (nbit == imtc_pkg::BITS_PER_BYTE - 4'h1) state <= E_ACK;
          end
        end
        E_ACK: begin
          if (tick) begin
            case (phase)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl_oe <= 1'b0;
              2'h2: rsp.ack <= ~sda_in;
              default: scl_oe <= 1'b1;
            endcase
          end
          if (last_phase) begin
            state <= E_IDLE;
            rsp.done <= 1'b1;
          end
        end
        E_STOP: begin
          // sda low, scl released, sda released
          if (tick) begin
            case (phase)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b0;
              default: sda_oe <= 1'b0;
            endcase
          end
          if (last_phase) begin
            state <= E_IDLE;
            rsp.done <= 1'b1;
          end
        end
        default: state <= E_IDLE;
      endcase
    end
  end
endmodule : imtc_bit_engine

// ### imtc_top.sv
// two-wire master transmitter control block with ahb-lite registers
//
// Notes on behaviour
// - four modes exist; only master paths built
// - no mode refused by hardware itself
// - start condition precedes any master mode
// - address write bit selects transmit mode
// - read bit high, write bit low
// - ack low, nack high; bytes 8 bits
// - wait flag set holds transfer suspended
// - status low three bits read zero
// - wait, start, enable set sends start
// - enable clear means no bus activity
// - writing one clears wait flag
// - start waits until bus is free
// - wait flag set after start sent
// - flag set after address ack sampled
// - flag and status after data ack
// - start done reports code 08
// - wait, stop, enable set sends stop
// - no wait flag after stop
// - data write while flag low collides
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module imtc_top #(
  parameter logic [7:0] DIV_DEFAULT = imtc_pkg::DIV_RESET
) (
  // ahb-lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // two-wire bus pins, oe high pulls the line low
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  typedef enum logic [2:0] {M_IDLE, M_WAITBUS, M_RUN, M_HOLD, M_STOP}
    imtc_mst_t;

  // control bits, one flop each
  logic wait_flag;
  logic ack_enable;
  logic start_request;
  logic stop_request;
  logic write_collision_flag;
  logic iface_en;
  logic iface_irq_enable;
  // data, status and bit-rate registers
  logic [7:0] shift_data_reg;
  logic [7:0] serial_status;
  logic [7:0] divider;
  logic [7:0] div_cnt;
  logic tick;
  // sequencer state
  imtc_mst_t mstate;
  logic addr_phase;
  logic read_mode;
  logic first_byte;
  logic mstate_own;
  // request to and answer from the bit engine
  imtc_pkg::imtc_req_t req;
  imtc_pkg::imtc_rsp_t rsp;
  logic eng_scl_oe;
  logic eng_sda_oe;
  logic [7:0] rx_byte;

  // status posted once a byte is out and its answer bit is in
  function automatic logic [7:0] byte_status(input logic addr,
      input logic rd, input logic ack);
    logic [7:0] code;
    if (addr && rd) begin
      code = ack ? imtc_pkg::ST_AR_ACK : imtc_pkg::ST_AR_NACK;
    end else if (addr) begin
      code = ack ? imtc_pkg::ST_AW_ACK : imtc_pkg::ST_AW_NACK;
    end else begin
      code = ack ? imtc_pkg::ST_D_ACK : imtc_pkg::ST_D_NACK;
    end
    return code;
  endfunction : byte_status

  // read words carry one byte, upper bits zero
  function automatic logic [31:0] rd_word(input logic [7:0] v);
    return {24'h000000, v};
  endfunction : rd_word

  // two-flop synchronisers on the pins; only the second flop is read
  logic scl_m;
  logic scl_s;
  logic sda_m;
  logic sda_s;
  logic sda_prev;
  logic bus_busy;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
    end
  end

  // bus busy from any observed start/stop, our own included
  wire start_seen = scl_s && sda_prev && !sda_s;
  wire stop_seen = scl_s && !sda_prev && sda_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_prev <= 1'b1;
      bus_busy <= 1'b0;
    end else begin
      sda_prev <= sda_s;
      if (!iface_en) bus_busy <= 1'b0;
      else if (start_seen) bus_busy <= 1'b1;
      else if (stop_seen) bus_busy <= 1'b0;
    end
  end

  // quarter-bit enable divider; held at zero while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 8'h00;
    end else if (!iface_en || div_cnt == divider) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign tick = iface_en && div_cnt == divider;

  // ahb address phase capture
  logic dp_write;
  logic dp_read;
  logic [7:0] dp_addr;
  wire ap_valid = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_write <= ap_valid && hwrite;
      dp_read <= ap_valid && !hwrite;
      if (ap_valid) dp_addr <= haddr[7:0];
    end
  end
  // no wait states and never an error response
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // decoded write strobes, data in the data phase
  wire wr_ctrl = dp_write && dp_addr == imtc_pkg::OFF_CONTROL;
  wire wr_data = dp_write && dp_addr == imtc_pkg::OFF_DATA;
  wire wr_div = dp_write && dp_addr == imtc_pkg::OFF_DIVIDER;
  wire [7:0] wb = hwdata[7:0];
  wire clr_wait = wr_ctrl && wb[imtc_pkg::B_WAIT];

  // control word assembled by field position; reserved bit reads zero
  logic [7:0] ctrl_rd;
  assign ctrl_rd[imtc_pkg::B_WAIT] = wait_flag;
  assign ctrl_rd[imtc_pkg::B_ACKEN] = ack_enable;
  assign ctrl_rd[imtc_pkg::B_START] = start_request;
  assign ctrl_rd[imtc_pkg::B_STOP] = stop_request;
  assign ctrl_rd[imtc_pkg::B_WCOL] = write_collision_flag;
  assign ctrl_rd[imtc_pkg::B_EN] = iface_en;
  assign ctrl_rd[imtc_pkg::B_RSVD] = 1'b0;
  assign ctrl_rd[imtc_pkg::B_IRQEN] = iface_irq_enable;
  // prescaler bits always read as zero
  wire [7:0] status_masked = serial_status & imtc_pkg::STATUS_MASK;

  // read mux, combinational from the captured address
  always_comb begin
    case (dp_addr)
      imtc_pkg::OFF_CONTROL: hrdata = rd_word(ctrl_rd);
      imtc_pkg::OFF_DATA: hrdata = rd_word(shift_data_reg);
      imtc_pkg::OFF_STATUS: hrdata = rd_word(status_masked);
      imtc_pkg::OFF_DIVIDER: hrdata = rd_word(divider);
      default: hrdata = 32'h00000000;
    endcase
    if (!dp_read) hrdata = 32'h00000000;
  end

  // engine done, and the event that sets the wait flag
  wire eng_done = rsp.done;
  wire set_wait = eng_done && mstate == M_RUN && req.cmd != imtc_pkg::CMD_STOP;

  // control bit store; hardware set beats software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_flag <= imtc_pkg::CTRL_RESET[imtc_pkg::B_WAIT];
      ack_enable <= imtc_pkg::CTRL_RESET[imtc_pkg::B_ACKEN];
      start_request <= imtc_pkg::CTRL_RESET[imtc_pkg::B_START];
      stop_request <= imtc_pkg::CTRL_RESET[imtc_pkg::B_STOP];
      iface_en <= imtc_pkg::CTRL_RESET[imtc_pkg::B_EN];
      iface_irq_enable <= imtc_pkg::CTRL_RESET[imtc_pkg::B_IRQEN];
      write_collision_flag <= 1'b0;
      divider <= DIV_DEFAULT;
    end else begin
      if (wr_ctrl) begin
        ack_enable <= wb[imtc_pkg::B_ACKEN];
        start_request <= wb[imtc_pkg::B_START];
        stop_request <= wb[imtc_pkg::B_STOP];
        iface_en <= wb[imtc_pkg::B_EN];
        iface_irq_enable <= wb[imtc_pkg::B_IRQEN];
      end
      if (set_wait) wait_flag <= 1'b1;
      else if (clr_wait) wait_flag <= 1'b0;
      // stop request self-clears once the stop is on the wire
      if (eng_done && req.cmd == imtc_pkg::CMD_STOP) stop_request <= 1'b0;
      if (wr_data && !wait_flag) write_collision_flag <= 1'b1;
      else if (wr_data) write_collision_flag <= 1'b0;
      if (wr_div) divider <= wb;
    end
  end

  // data register: bus writes land only while the flag is high; in read mode a received byte loads when its ack is done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_data_reg <= imtc_pkg::DATA_RESET;
    end else if (wr_data && wait_flag) begin
      shift_data_reg <= wb;
    end else if (eng_done && read_mode && !addr_phase) begin
      shift_data_reg <= rx_byte;
    end
  end

  // released control write: flag cleared with enable set
  wire go = clr_wait && wb[imtc_pkg::B_EN] && !wb[imtc_pkg::B_RSVD];
  wire go_start = go && wb[imtc_pkg::B_START];
  wire go_stop = go && wb[imtc_pkg::B_STOP] && !wb[imtc_pkg::B_START];

  // enable as it stands after this cycle's control write, so a start
  // written together with the enable bit is not lost
  wire en_now = wr_ctrl ? wb[imtc_pkg::B_EN] : iface_en;

  // transfer sequencer above the bit engine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mstate <= M_IDLE;
      req <= '{valid: 1'b0, cmd: imtc_pkg::CMD_START, data: 8'h00};
      serial_status <= imtc_pkg::ST_IDLE;
      addr_phase <= 1'b0;
      read_mode <= 1'b0;
      first_byte <= 1'b1;
    end else begin
      req.valid <= 1'b0;
      if (clr_wait) serial_status <= imtc_pkg::ST_IDLE;
      if (!en_now) begin
        mstate <= M_IDLE;
        first_byte <= 1'b1;
      end else begin
        case (mstate)
          M_IDLE, M_HOLD: begin
            // the engine sleeps until the flag is cleared
            if (go_stop) begin
              mstate <= M_STOP;
              req <= '{valid: 1'b1, cmd: imtc_pkg::CMD_STOP, data: 8'h00};
            end else if (go_start) begin
              mstate <= M_WAITBUS;
            end else if (go && mstate == M_HOLD) begin
              mstate <= M_RUN;
              req <= '{valid: 1'b1, cmd: imtc_pkg::CMD_BYTE,
                data: shift_data_reg};
            end
          end
          M_WAITBUS: begin
            // our own start marks the bus busy; a repeated start skips it
            if (!bus_busy || mstate_own) begin
              mstate <= M_RUN;
              req <= '{valid: 1'b1, cmd: imtc_pkg::CMD_START, data: 8'h00};
            end
          end
          M_RUN: begin
            if (eng_done) begin
              mstate <= M_HOLD;
              case (req.cmd)
                imtc_pkg::CMD_START: begin
                  serial_status <= first_byte ? imtc_pkg::ST_START
                    : imtc_pkg::ST_RSTART;
                  addr_phase <= 1'b1;
                  first_byte <= 1'b0;
                end
                default: begin
                  // address byte: its low bit picks the direction
                  if (addr_phase) read_mode <= req.data[0];
                  serial_status <= byte_status(addr_phase,
                    req.data[0], rsp.ack);
                  addr_phase <= 1'b0;
                end
              endcase
            end
          end
          M_STOP: begin
            if (eng_done) begin
              mstate <= M_IDLE;
              first_byte <= 1'b1;
              // a start bit written while the stop is still running follows it
              if (start_request) mstate <= M_WAITBUS;
            end
          end
          default: mstate <= M_IDLE;
        endcase
      end
    end
  end

  // own transfer in flight means the busy detector sees ourselves
  assign mstate_own = !first_byte;

  imtc_bit_engine u_engine (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .req(req),
    .rsp(rsp),
    .scl_in(scl_s),
    .sda_in(sda_s),
    .scl_oe(eng_scl_oe),
    .sda_oe(eng_sda_oe),
    .rx_byte(rx_byte)
  );

  // pins: engine holds scl low during the wait, only while enabled
  assign scl_oe = iface_en && eng_scl_oe;
  assign sda_oe = iface_en && eng_sda_oe;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
endmodule : imtc_top

// ### imtc_assertions.sv
// checker of bus-side and wire-side behaviour of the transmit control block
`timescale 1ns/1ps
module imtc_assertions #(
  parameter logic [7:0] DIV_DEFAULT = imtc_pkg::DIV_RESET
) (
  // ahb-lite side
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // wire side
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  localparam int WIN = 4;
  localparam int LIM = 64;
  logic dp_rd;
  logic dp_wr;
  logic en_q;
  logic [7:0] dp_a;
  wire logic take = hsel && hready && htrans[1];
  wire logic ctl_rd = dp_rd && dp_a == imtc_pkg::OFF_CONTROL;
  wire logic st_rd = dp_rd && dp_a == imtc_pkg::OFF_STATUS;
  // data phase trails an accepted address phase by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_rd <= 1'b0;
      dp_wr <= 1'b0;
      dp_a <= 8'h00;
    end else begin
      dp_rd <= take && !hwrite;
      dp_wr <= take && hwrite;
      dp_a <= haddr[7:0];
    end
  end
  // last written enable, so quiet lines can be demanded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b0;
    end else if (dp_wr && dp_a == imtc_pkg::OFF_CONTROL) begin
      en_q <= hwdata[imtc_pkg::B_EN];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_status_low_zero: assert property (st_rd |-> hrdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_hold_while_wait: assert property (
    ctl_rd && hrdata[imtc_pkg::B_WAIT] && hrdata[imtc_pkg::B_EN]
    |-> ##[0:WIN] scl_oe) else $error("clock not held while flag set");
  a_quiet_disabled: assert property (
    !en_q [*3] |-> !scl_oe && !sda_oe) else $error("lines driven while off");
  a_no_hold_after_stop: assert property (
    $fell(sda_oe) && !scl_oe |-> !scl_oe [*8])
    else $error("clock held after stop");
  a_start_shape: assert property (
    $rose(sda_oe) && !scl_oe |-> scl_in && $past(sda_in))
    else $error("start with clock low or data line taken");
  a_start_hold: assert property (
    $rose(sda_oe) && !scl_oe |-> ##[1:LIM] scl_oe)
    else $error("clock not pulled after start");
  a_reserved_zero: assert property (
    ctl_rd |-> !hrdata[imtc_pkg::B_RSVD] && hrdata[31:8] == 24'h0)
    else $error("reserved control bits not zero");
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_stop: cover property ($fell(sda_oe) && !scl_oe);
  c_nack: cover property (st_rd && hrdata[7:0] == imtc_pkg::ST_D_NACK);
endmodule : imtc_assertions
bind imtc_top imtc_assertions #(.DIV_DEFAULT(DIV_DEFAULT)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe));

// ### imtc_slave_model.sv
// behavioural slave receiver on the two-wire bus
`timescale 1ns/1ps
module imtc_slave_model (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // bench control and observation
  input wire logic nack,
  output logic sda_pull,
  output logic [7:0] rx_byte,
  output int n_rx,
  output int n_start,
  output int n_stop
);
  logic [7:0] sh = 8'h00;
  int bits = 0;
  logic busy = 1'b0;
  initial begin
    sda_pull = 1'b0;
    rx_byte = 8'h00;
    n_rx = 0;
    n_start = 0;
    n_stop = 0;
  end
  // start and stop are data edges while the clock is high
  always @(negedge sda) begin
    if (scl) begin
      n_start = n_start + 1;
      busy = 1'b1;
      bits = 0;
    end
  end
  always @(posedge sda) begin
    if (scl && busy) begin
      n_stop = n_stop + 1;
      busy = 1'b0;
    end
  end
  // bits taken on the clock rise, msb first
  always @(posedge scl) begin
    if (busy && bits < 8) begin
      sh = {sh[6:0], sda};
      bits = bits + 1;
    end
  end
  // answer bit held from the eighth fall to the ninth; released goes high
  always @(negedge scl) begin
    if (busy && bits == 8) begin
      sda_pull = !nack;
      rx_byte = sh;
      n_rx = n_rx + 1;
      bits = 9;
    end else if (bits == 9) begin
      sda_pull = 1'b0;
      bits = 0;
    end
  end
endmodule : imtc_slave_model

// ### tb.sv
// self-checking bench for the two-wire transmit control block
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dp_rd;
  logic scl_oe, sda_oe, scl_out, sda_out, ext_sda, nack, slv_pull;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] rx_byte, b;
  int n_rx, n_start, n_stop, n_mismatch, total_checks, cyc;
  logic [31:0] rq[$];
  logic [31:0] mq[$];
  logic [7:0] bq[$];
  // open-drain wires with pull-ups
  wire logic scl = !scl_oe;
  wire logic sda = !(sda_oe || slv_pull || ext_sda);
  imtc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  imtc_slave_model slv (.scl(scl), .sda(sda), .nack(nack),
    .sda_pull(slv_pull), .rx_byte(rx_byte), .n_rx(n_rx),
    .n_start(n_start), .n_stop(n_stop));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // one single transfer; hready is looked at just before each edge
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] e, input logic [31:0] m);
    logic rdy;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    if (!w) begin
      rq.push_back(e);
      mq.push_back(m);
    end
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      @(posedge hclk);
    end while (!rdy);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      r = hrdata;
      @(posedge hclk);
    end while (!rdy);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d}, 32'h0, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
      input logic [7:0] m);
    xfer(1'b0, a, 32'h0, {24'h0, e}, {24'h0, m});
  endtask : rd
  // poll the wait flag, bounded
  task automatic poll();
    r = 32'h0;
    for (int i = 0; i < 400 && !r[7]; i++) begin
      rd(imtc_pkg::OFF_CONTROL, 8'h04, 8'h06);
    end
    check({31'h0, r[7]}, 32'h1);
  endtask : poll
  task automatic step(input logic [7:0] c, input logic [7:0] st);
    wr(imtc_pkg::OFF_CONTROL, c);
    poll();
    rd(imtc_pkg::OFF_STATUS, st, 8'hff);
  endtask : step
  // read notes are taken off in data-phase order
  always @(posedge hclk) dp_rd <= hsel && htrans[1] && !hwrite && hreadyout;
  always @(negedge hclk) begin
    if (dp_rd && rq.size() > 0) begin
      check(hrdata & mq[0], rq[0] & mq[0]);
      void'(rq.pop_front());
      void'(mq.pop_front());
    end
  end
  always @(n_rx) check({24'h0, rx_byte}, {24'h0, bq.pop_front()});
  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, ext_sda, nack} = 5'h00;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
    {n_mismatch, total_checks, cyc} = {32'h0, 32'h0, 32'h0};
    void'($urandom(32'h0ec435dd));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(imtc_pkg::OFF_CONTROL, imtc_pkg::CTRL_RESET, 8'hff);
    rd(imtc_pkg::OFF_DATA, imtc_pkg::DATA_RESET, 8'hff);
    rd(imtc_pkg::OFF_STATUS, imtc_pkg::ST_IDLE, 8'hff);
    rd(imtc_pkg::OFF_DIVIDER, imtc_pkg::DIV_RESET, 8'hff);
    rd(8'h10, 8'h00, 8'hff);
    wr(imtc_pkg::OFF_DIVIDER, 8'h02);
    // start request with enable clear stays off the wires
    wr(imtc_pkg::OFF_CONTROL, 8'ha0);
    repeat (200) @(posedge hclk);
    check(32'(n_start), 32'h0);
    // data write with the flag low is dropped and flagged
    wr(imtc_pkg::OFF_DATA, 8'h5a);
    rd(imtc_pkg::OFF_CONTROL, 8'h08, 8'h08);
    rd(imtc_pkg::OFF_DATA, imtc_pkg::DATA_RESET, 8'hff);
    step(8'ha4, imtc_pkg::ST_START);
    b = {7'($urandom), 1'b0};
    wr(imtc_pkg::OFF_DATA, b);
    bq.push_back(b);
    // control write without the clear bit must not resume
    wr(imtc_pkg::OFF_CONTROL, 8'h04);
    repeat (100) @(posedge hclk);
    rd(imtc_pkg::OFF_CONTROL, 8'h80, 8'h88);
    check(32'(n_rx), 32'h0);
    step(8'h84, imtc_pkg::ST_AW_ACK);
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      wr(imtc_pkg::OFF_DATA, b);
      bq.push_back(b);
      nack <= (i == 2);
      step(8'h84, (i == 2) ? imtc_pkg::ST_D_NACK : imtc_pkg::ST_D_ACK);
    end
    nack <= 1'b0;
    wr(imtc_pkg::OFF_CONTROL, 8'h94);
    repeat (200) @(posedge hclk);
    rd(imtc_pkg::OFF_CONTROL, 8'h00, 8'h80);
    rd(imtc_pkg::OFF_STATUS, imtc_pkg::ST_IDLE, 8'hff);
    check(32'(n_stop), 32'h1);
    // another master owns the bus: start waits for its stop
    ext_sda <= 1'b1;
    repeat (20) @(posedge hclk);
    wr(imtc_pkg::OFF_CONTROL, 8'ha4);
    repeat (150) @(posedge hclk);
    check(32'(n_start), 32'h2);
    ext_sda <= 1'b0;
    poll();
    rd(imtc_pkg::OFF_STATUS, imtc_pkg::ST_START, 8'hff);
    b = {7'($urandom), 1'b1};
    bq.push_back(b);
    nack <= 1'b1;
    wr(imtc_pkg::OFF_DATA, b);
    step(8'h84, imtc_pkg::ST_AR_NACK);
    nack <= 1'b0;
    wr(imtc_pkg::OFF_CONTROL, 8'h94);
    repeat (200) @(posedge hclk);
    check(32'(n_stop), 32'h3);
    stop_test();
  end
endmodule : tb
